// ---- src/adc_ctrl_defines.svh ----
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

// result width and number of successive-approximation steps
`define ADC_CODE_W 8
`define ADC_STEP_MSB 3'h7
`define ADC_STEP_LSB 3'h0
// first trial code: half of full scale, 256 equal steps
`define ADC_TRIAL_INIT 8'h80
`define ADC_RESULT_RST 8'h00
// hysteresis counter bounds for the clock input stage
`define ADC_HYST_MAX 2'h3
`define ADC_HYST_MIN 2'h0

`endif

// ---- src/adc_ctrl_pkg.sv ----
`include "adc_ctrl_defines.svh"

package adc_ctrl_pkg;

  typedef struct packed
  {
    logic cs_n;
    logic rd_n;
    logic wr_n;
  } bus_ctl_t;

  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT
  } conv_state_t;

endpackage : adc_ctrl_pkg

// ---- src/osc_schmitt.sv ----
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"

module osc_schmitt
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic osc_input,
  output logic tick,
  output logic osc_resistor_node
);

  logic [1:0] hyst;
  logic level;

  // saturating counter gives hysteresis: a short glitch cannot flip level
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      hyst <= `ADC_HYST_MIN;
    else if (osc_input && hyst != `ADC_HYST_MAX)
      hyst <= hyst + 2'h1;
    else if (!osc_input && hyst != `ADC_HYST_MIN)
      hyst <= hyst - 2'h1;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      level <= 1'b0;
    else if (hyst == `ADC_HYST_MAX)
      level <= 1'b1;
    else if (hyst == `ADC_HYST_MIN)
      level <= 1'b0;
  end

  // one enable pulse per rising edge of the filtered clock
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      tick <= 1'b0;
    else
      tick <= (hyst == `ADC_HYST_MAX) && !level;
  end

  // inverted level drives the external rc; a host clock simply overrides it
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      osc_resistor_node <= 1'b1;
    else
      osc_resistor_node <= !level;
  end

endmodule : osc_schmitt

// ---- src/adc_start_ctrl.sv ----
// Function
// - chip select and write low, then released, abort and restart conversion
// - an aborted conversion leaves the result latch untouched
// - conversion_done_n stays high for an aborted conversion
// - conversion clock from host clock or rc on a hysteresis input
// - span split into 256 equal steps, unsigned 8-bit result
// - straight binary code, all zeros at zero, all ones full scale
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"

module adc_start_ctrl
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire adc_ctrl_pkg::bus_ctl_t ctl,
  input wire logic osc_input,
  input wire logic comp_hi,
  output logic osc_resistor_node,
  output logic [`ADC_CODE_W-1:0] dac_code,
  output logic [`ADC_CODE_W-1:0] data_out,
  output logic data_oe,
  output logic conversion_done_n
);

  adc_ctrl_pkg::conv_state_t state;
  logic tick;
  logic wr_sel;
  logic rd_sel;
  logic armed;
  logic start;
  logic finish;
  logic [2:0] bit_idx;
  logic [`ADC_CODE_W-1:0] next_code;

  osc_schmitt u_osc
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .osc_input(osc_input),
    .tick(tick),
    .osc_resistor_node(osc_resistor_node)
  );

  assign wr_sel = !ctl.cs_n && !ctl.wr_n;
  assign rd_sel = !ctl.cs_n && !ctl.rd_n;
  // conversion starts on release, so a long strobe only delays it
  assign start = armed && !wr_sel;
  assign finish = (state == adc_ctrl_pkg::ST_CONVERT) && tick &&
                  (bit_idx == `ADC_STEP_LSB) && !start;

  // comparator high means input at or above the trial: keep the bit
  always_comb
  begin
    next_code = dac_code;
    if (!comp_hi)
      next_code[bit_idx] = 1'b0;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      armed <= 1'b0;
    else
      armed <= wr_sel;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= adc_ctrl_pkg::ST_IDLE;
      bit_idx <= `ADC_STEP_MSB;
      dac_code <= `ADC_TRIAL_INIT;
    end
    else if (start)
    begin
      // restart reloads the successive-approximation register with the first trial code
      state <= adc_ctrl_pkg::ST_SAMPLE;
      bit_idx <= `ADC_STEP_MSB;
      dac_code <= `ADC_TRIAL_INIT;
    end
    else
    begin
      case (state)
        adc_ctrl_pkg::ST_IDLE:
          state <= adc_ctrl_pkg::ST_IDLE;
        adc_ctrl_pkg::ST_SAMPLE:
          if (tick)
            state <= adc_ctrl_pkg::ST_CONVERT;
        adc_ctrl_pkg::ST_CONVERT:
          if (tick)
          begin
            dac_code <= next_code;
            if (bit_idx == `ADC_STEP_LSB)
              state <= adc_ctrl_pkg::ST_IDLE;
            else
            begin
              dac_code[bit_idx - 3'h1] <= 1'b1;
              bit_idx <= bit_idx - 3'h1;
            end
          end
        default:
          state <= adc_ctrl_pkg::ST_IDLE;
      endcase
    end
  end

  // latch written only on a finished conversion
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      data_out <= `ADC_RESULT_RST;
    else if (finish)
      data_out <= next_code;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      data_oe <= 1'b0;
    else
      data_oe <= rd_sel;
  end

  // completion beats a simultaneous strobe so the event is not lost;
  // an abort never reaches finish, so done stays high
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      conversion_done_n <= 1'b1;
    else if (finish)
      conversion_done_n <= 1'b0;
    else if (wr_sel || rd_sel)
      conversion_done_n <= 1'b1;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_abort_restart: assert property (
    start |=> state == adc_ctrl_pkg::ST_SAMPLE &&
              dac_code == `ADC_TRIAL_INIT)
    else $error("restart did not reload the trial code");

  a_result_hold: assert property (
    (start && state != adc_ctrl_pkg::ST_IDLE) |=> $stable(data_out))
    else $error("aborted conversion changed the result");

  a_no_abort_done: assert property (
    (conversion_done_n && !finish) |=> conversion_done_n)
    else $error("done fell without a finished conversion");

  a_step_on_tick: assert property (
    (state == adc_ctrl_pkg::ST_CONVERT && !tick && !start)
      |=> $stable(bit_idx) && $stable(dac_code))
    else $error("approximation stepped without a clock tick");

  a_sample_to_msb: assert property (
    (state == adc_ctrl_pkg::ST_SAMPLE && tick && !start)
      |=> state == adc_ctrl_pkg::ST_CONVERT && bit_idx == `ADC_STEP_MSB)
    else $error("conversion did not begin at the top bit");

  a_binary_code: assert property (
    finish |=> data_out == $past(next_code) &&
               (!$past(comp_hi) || data_out[0] == 1'b1))
    else $error("result latch does not hold the final code");

  a_done_low: assert property (
    finish |=> !conversion_done_n ##1 (!conversion_done_n || $past(wr_sel)
                                       || $past(rd_sel)))
    else $error("done did not fall or rose without a strobe");

  a_done_release: assert property (
    (!conversion_done_n && (wr_sel || rd_sel) && !finish)
      |=> conversion_done_n)
    else $error("strobe did not release done");

  a_latch_hold: assert property (
    !finish |=> $stable(data_out))
    else $error("result latch changed without a finished conversion");

  a_finish_idle: assert property (
    finish |=> state == adc_ctrl_pkg::ST_IDLE)
    else $error("converter kept running after the last bit");

  a_idle_hold: assert property (
    (state == adc_ctrl_pkg::ST_IDLE && !start)
      |=> state == adc_ctrl_pkg::ST_IDLE)
    else $error("converter left idle without a start");

  a_sample_wait: assert property (
    (state == adc_ctrl_pkg::ST_SAMPLE && !tick && !start)
      |=> state == adc_ctrl_pkg::ST_SAMPLE)
    else $error("sampling ended without a clock tick");

  // trial bits walk from the top down, one per conversion tick
  a_bit_walk: assert property (
    (state == adc_ctrl_pkg::ST_CONVERT && tick && !start &&
     bit_idx != `ADC_STEP_LSB) |=> bit_idx == $past(bit_idx) - 3'h1)
    else $error("trial bit did not step down by one");

  a_trial_bit: assert property (
    (state == adc_ctrl_pkg::ST_CONVERT && tick && !start &&
     bit_idx != `ADC_STEP_LSB) |=> dac_code[bit_idx] == 1'b1)
    else $error("next trial bit was not raised");

  a_read_enable: assert property (
    (rd_sel && !finish) |=> data_oe && conversion_done_n)
    else $error("read did not enable the bus or release done");

  a_bus_released: assert property (
    !rd_sel |=> !data_oe)
    else $error("data bus still driven after the read ended");

  c_complete: cover property (finish ##1 !conversion_done_n);
  c_abort: cover property (state == adc_ctrl_pkg::ST_CONVERT && start);
  c_read: cover property (!conversion_done_n && rd_sel ##1 data_oe);
  c_free_loop: cover property (finish ##1 (!conversion_done_n && wr_sel));

endmodule : adc_start_ctrl

// ---- verif/host_bus_model.sv ----
`timescale 1ns/1ps
module host_bus_model
(
  input wire logic clk,
  output adc_ctrl_pkg::bus_ctl_t ctl
);
  initial ctl = 3'h7;
  task automatic start_conv();
    @(posedge clk) ctl <= 3'h2;
    @(posedge clk) ctl <= 3'h7;
  endtask : start_conv
  // held two edges so the enable is seen before release
  task automatic read_res();
    @(posedge clk) ctl <= 3'h1;
    repeat (2) @(posedge clk);
    ctl <= 3'h7;
  endtask : read_res
endmodule : host_bus_model

// ---- verif/adc_start_ctrl_tb_top.sv ----
`timescale 1ns/1ps
module adc_start_ctrl_tb_top;
  logic clk = 0, sys_rst = 1, osc_input = 0, free = 0, kick_n = 1, pd;
  logic orn, rc = 0;
  logic [3:0] rc_dly = 4'h0;
  logic [7:0] ain = 8'h00, v, last, dac_code, data_out;
  logic data_oe, conversion_done_n, comp_hi;
  logic [31:0] seed = 32'h0000_0020;
  adc_ctrl_pkg::bus_ctl_t host_ctl, ctl;
  int bad_count = 0, checks = 0, n, f, oc = 0, exp_q[$];
  // free running: select grounded, write tied to done
  assign ctl = free ? adc_ctrl_pkg::bus_ctl_t'({2'h1,
    conversion_done_n & kick_n}) : host_ctl;
  assign comp_hi = (ain >= dac_code);
  host_bus_model host_bus_model_inst(.clk(clk), .ctl(host_ctl));
  adc_start_ctrl adc_start_ctrl_inst(.clk(clk), .sys_rst(sys_rst),
    .ctl(ctl), .osc_input(osc_input), .comp_hi(comp_hi),
    .osc_resistor_node(orn), .dac_code(dac_code), .data_out(data_out),
    .data_oe(data_oe), .conversion_done_n(conversion_done_n));
  initial forever #2 clk = ~clk;
  // host clock on the conversion input, ten cycles a period;
  // rc mode feeds the resistor node back through a short lag
  always @(posedge clk)
  begin
    oc <= (oc == 4) ? 0 : oc + 1;
    rc_dly <= {rc_dly[2:0], orn};
    if (rc)
      osc_input <= rc_dly[3];
    else if (oc == 4)
      osc_input <= ~osc_input;
  end
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
    checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic wait_done();
    n = 0;
    tick();
    while (conversion_done_n !== 1'b0 && n < 400)
    begin
      tick();
      n++;
    end
    if (conversion_done_n !== 1'b0)
    begin
      bad_count++;
      print_verdict();
    end
  endtask : wait_done
  // a new start drops whatever was pending
  task automatic start(logic [7:0] x);
    @(posedge clk) ain <= x;
    exp_q.delete();
    exp_q.push_back(x);
    host_bus_model_inst.start_conv();
  endtask : start
  initial
  begin
    repeat (19) @(posedge clk);
    #1;
    chk("rst result", 8'h00, data_out);
    chk("rst done", 8'h01, {7'h00, conversion_done_n});
    chk("rst oe", 8'h00, {7'h00, data_oe});
    chk("rst rc node", 8'h01, {7'h00, orn});
    @(posedge clk) sys_rst <= 0;
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk) rc <= (i == 4);
      seed = xs(seed);
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : (i == 2) ? 8'hfe : seed[7:0];
      start(v);
      wait_done();
      last = 8'(exp_q.pop_front());
      chk("result", last, data_out);
      host_bus_model_inst.read_res();
      #1;
      chk("read oe", 8'h01, {7'h00, data_oe});
      chk("read done", 8'h01, {7'h00, conversion_done_n});
      tick();
      chk("oe off", 8'h00, {7'h00, data_oe});
    end
    start(8'h5a);
    for (int k = 0; k < 40; k++)
    begin
      tick();
      chk("abort done", 8'h01, {7'h00, conversion_done_n});
    end
    chk("kept", last, data_out);
    start(8'ha5);
    tick();
    chk("abort kept", last, data_out);
    chk("abort quiet", 8'h01, {7'h00, conversion_done_n});
    wait_done();
    chk("restart", 8'(exp_q.pop_front()), data_out);
    @(posedge clk)
    begin
      free <= 1;
      kick_n <= 0;
    end
    @(posedge clk) kick_n <= 1;
    f = 0;
    pd = 1;
    for (int k = 0; k < 600; k++)
    begin
      tick();
      f += (pd === 1'b1 && conversion_done_n === 1'b0);
      pd = conversion_done_n;
    end
    chk("free runs", 8'h01, 8'(f >= 3));
    chk("free result", ain, data_out);
    print_verdict();
  end
endmodule : adc_start_ctrl_tb_top
